// ---- nvpo_pkg.sv ----
package nvpo_pkg;

    // Register byte offsets on the APB bus
    localparam logic [7:0] OFS_CMD_STATUS = 8'h00;
    localparam logic [7:0] OFS_CMD_CONFIG = 8'h04;
    localparam logic [7:0] OFS_ERR_CONFIG = 8'h08;
    localparam logic [7:0] OFS_ERR_STATUS = 8'h0C;
    localparam logic [7:0] OFS_PARAM_INDEX = 8'h10;
    localparam logic [7:0] OFS_PARAM_WORD0 = 8'h14;
    localparam logic [7:0] OFS_PARAM_WORD1 = 8'h18;
    localparam logic [7:0] OFS_PARAM_WORD2 = 8'h1C;
    localparam logic [7:0] OFS_PARAM_WORD3 = 8'h20;
    localparam logic [7:0] OFS_PFLASH_PROT = 8'h24;
    localparam logic [7:0] OFS_EEPROM_PROT = 8'h28;
    localparam logic [7:0] OFS_PROT_STATUS = 8'h2C;

    // Field positions
    localparam int CST_CMD_COMPLETE = 7;
    localparam int CST_ACCESS_ERROR = 5;
    localparam int CST_PROT_VIOLATION = 4;
    localparam int CCFG_CMD_COMPLETE_IE = 7;
    localparam int ECFG_SINGLE_FAULT_IE = 0;
    localparam int EST_SINGLE_FAULT = 0;
    localparam int PST_OVERRIDE_ACTIVE = 7;

    // Reset values
    localparam logic [7:0] PFLASH_PROT_RST = 8'h00;
    localparam logic [7:0] EEPROM_PROT_RST = 8'h00;
    localparam logic [2:0] PARAM_INDEX_RST = 3'h0;
    localparam logic [15:0] PARAM_WORD_RST = 16'h0000;

    // Command encoding
    localparam logic [7:0] CMD_PROT_OVERRIDE = 8'h13;
    localparam logic [15:0] KEY_ERASED = 16'hFFFF;
    localparam logic [1:0] SEL_NONE = 2'h0;
    localparam logic [2:0] IDX_KEY_ONLY = 3'h1;
    localparam logic [2:0] IDX_PFLASH = 3'h2;
    localparam logic [2:0] IDX_EEPROM = 3'h3;

    // Execution time of one command, in clock cycles
    localparam int CNT_W = 4;
    localparam logic [CNT_W-1:0] EXEC_CYCLES = 4'h4;

endpackage

// ---- nvpo_sync.sv ----
`timescale 1ns/1ps
`default_nettype none

// Two-stage synchroniser; stage one is read only by stage two
module nvpo_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    logic [W-1:0] meta_r;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= '0;
            q <= '0;
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end

endmodule // nvpo_sync

`default_nettype wire

// ---- nvpo_top.sv ----
//
// Behaviour
// (RULE_01) Software puts command 0x13 in word0 upper byte, selection in bits 1:0.
// (RULE_02) Software puts key in word1, new flash byte in word2, eeprom byte word3.
// (RULE_03) An all-ones supplied key is invalid and disables the override.
// (RULE_04) A valid key differing from the stored key disables the override.
// (RULE_05) On match, save both protection registers, then overwrite selected ones.
// (RULE_06) Selection bit 0 updates flash protection, bit 1 updates eeprom protection.
// (RULE_07) Override values are taken unrestricted, raising or lowering protection.
// (RULE_08) A successful override sets the override-active status bit.
// (RULE_09) Bad or invalid key restores both registers and clears override-active.
// (RULE_10) An erased stored key keeps the override feature disabled for good.
// (RULE_11) A launch with access error leaves both protection registers unchanged.
// (RULE_12) The save area holds one entry, refreshed by each override.
// (RULE_13) Direct writes during an override are lost on restore.
// (RULE_14) Restore reloads saved values, never reset values.
// (RULE_15) Access error unless parameter index is 001, 010 or 011.
// (RULE_16) Access error when the command is unavailable in the present mode.
// (RULE_17) Access error when a restore is needed but override-active is clear.
// (RULE_18) Access error when selection is 00 and index is 010 or 011.
// (RULE_19) Access error when selection is 00, index 001 and key valid.
// (RULE_20) Command interrupt follows complete flag and its enable.
// (RULE_21) Error interrupt follows single-fault flag and its enable.
// (RULE_22) Wait mode does not disturb the block; command interrupt still wakes.
// (RULE_23) Clearing complete flag launches; the device sets it again when done.
// (RULE_24) No violation or verify status for this command, only access error.
//
// Our own choices: the APB slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module nvpo_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [15:0] cfg_key,
    input wire logic cmd_allowed,
    input wire logic single_fault_evt,
    output logic cmd_irq,
    output logic err_irq
);

    typedef enum logic {NVPO_IDLE, NVPO_BUSY} nvpo_state_t;

    nvpo_state_t st_r;
    logic [nvpo_pkg::CNT_W-1:0] cnt_r;
    logic pready_r, pslverr_r;
    logic [31:0] prdata_r;
    logic [15:0] word0_r, word1_r, word2_r, word3_r;
    logic [2:0] idx_r;
    logic cmd_complete_flag_r, access_error_r, prot_violation_r;
    logic cmd_complete_irq_en_r, single_fault_irq_en_r, single_fault_flag_r;
    logic [7:0] pflash_prot_r, eeprom_prot_r, save_pflash_r, save_eeprom_r;
    logic override_active_r;
    logic cmd_irq_r, err_irq_r;
    logic sf_sync, sf_prev_r, sf_rise;
    logic setup, wr_acc, busy, launch, done;
    logic [31:0] rd_data;
    logic rd_hit;
    logic key_valid, key_match, need_restore, cmd_err;
    logic [1:0] sel;

    // Fault strobe comes from the array read path, so resynchronise it
    nvpo_sync #(.W(1)) u_sf_sync (
        .clk(pclk),
        .rst_n(presetn),
        .d(single_fault_evt),
        .q(sf_sync)
    );

    assign setup = psel & ~penable;
    assign wr_acc = psel & penable & pready_r & pwrite;
    assign busy = (st_r == NVPO_BUSY);
    // Writing one to the set complete flag clears it and starts the command
    assign launch = wr_acc && (paddr == nvpo_pkg::OFS_CMD_STATUS) && // RULE_23
                    pwdata[nvpo_pkg::CST_CMD_COMPLETE] && cmd_complete_flag_r;
    assign done = busy && (cnt_r == '0);
    assign sf_rise = sf_sync & ~sf_prev_r;
    assign sel = word0_r[1:0];

    // Key check and launch errors, judged on frozen parameters at completion
    always_comb begin
        key_valid = (word1_r != nvpo_pkg::KEY_ERASED); // RULE_03
        key_match = key_valid && (cfg_key != nvpo_pkg::KEY_ERASED) && // RULE_10
                    (word1_r == cfg_key); // RULE_04
        need_restore = !key_match;
        cmd_err = (word0_r[15:8] != nvpo_pkg::CMD_PROT_OVERRIDE) ||
                  !(idx_r == nvpo_pkg::IDX_KEY_ONLY || idx_r == nvpo_pkg::IDX_PFLASH ||
                    idx_r == nvpo_pkg::IDX_EEPROM) || // RULE_15
                  !cmd_allowed || // RULE_16
                  (need_restore && !override_active_r) || // RULE_17
                  (sel == nvpo_pkg::SEL_NONE && (idx_r == nvpo_pkg::IDX_PFLASH ||
                    idx_r == nvpo_pkg::IDX_EEPROM)) || // RULE_18
                  (sel == nvpo_pkg::SEL_NONE && idx_r == nvpo_pkg::IDX_KEY_ONLY &&
                    key_valid); // RULE_19
    end

    // Read decode; unmapped addresses answer with an error and zero data
    always_comb begin
        rd_data = 32'h0000_0000;
        rd_hit = 1'b1;
        unique case (paddr)
            nvpo_pkg::OFS_CMD_STATUS: begin
                rd_data[nvpo_pkg::CST_CMD_COMPLETE] = cmd_complete_flag_r;
                rd_data[nvpo_pkg::CST_ACCESS_ERROR] = access_error_r;
                rd_data[nvpo_pkg::CST_PROT_VIOLATION] = prot_violation_r;
            end
            nvpo_pkg::OFS_CMD_CONFIG:
                rd_data[nvpo_pkg::CCFG_CMD_COMPLETE_IE] = cmd_complete_irq_en_r;
            nvpo_pkg::OFS_ERR_CONFIG:
                rd_data[nvpo_pkg::ECFG_SINGLE_FAULT_IE] = single_fault_irq_en_r;
            nvpo_pkg::OFS_ERR_STATUS:
                rd_data[nvpo_pkg::EST_SINGLE_FAULT] = single_fault_flag_r;
            nvpo_pkg::OFS_PARAM_INDEX: rd_data[2:0] = idx_r;
            nvpo_pkg::OFS_PARAM_WORD0: rd_data[15:0] = word0_r;
            nvpo_pkg::OFS_PARAM_WORD1: rd_data[15:0] = word1_r;
            nvpo_pkg::OFS_PARAM_WORD2: rd_data[15:0] = word2_r;
            nvpo_pkg::OFS_PARAM_WORD3: rd_data[15:0] = word3_r;
            nvpo_pkg::OFS_PFLASH_PROT: rd_data[7:0] = pflash_prot_r;
            nvpo_pkg::OFS_EEPROM_PROT: rd_data[7:0] = eeprom_prot_r;
            nvpo_pkg::OFS_PROT_STATUS:
                rd_data[nvpo_pkg::PST_OVERRIDE_ACTIVE] = override_active_r;
            default: rd_hit = 1'b0;
        endcase
    end

    // APB handshake: no wait states, data and error captured in setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
        end else begin
            pready_r <= setup;
            if (setup) begin
                pslverr_r <= !rd_hit;
                prdata_r <= pwrite ? 32'h0000_0000 : rd_data;
            end else if (pready_r) begin
                pslverr_r <= 1'b0;
                prdata_r <= 32'h0000_0000;
            end
        end
    end

    // Parameter words are frozen while a command runs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            idx_r <= nvpo_pkg::PARAM_INDEX_RST;
            word0_r <= nvpo_pkg::PARAM_WORD_RST;
            word1_r <= nvpo_pkg::PARAM_WORD_RST;
            word2_r <= nvpo_pkg::PARAM_WORD_RST;
            word3_r <= nvpo_pkg::PARAM_WORD_RST;
        end else if (wr_acc && !busy) begin
            unique case (paddr)
                nvpo_pkg::OFS_PARAM_INDEX: idx_r <= pwdata[2:0];
                nvpo_pkg::OFS_PARAM_WORD0: word0_r <= pwdata[15:0];
                nvpo_pkg::OFS_PARAM_WORD1: word1_r <= pwdata[15:0];
                nvpo_pkg::OFS_PARAM_WORD2: word2_r <= pwdata[15:0];
                nvpo_pkg::OFS_PARAM_WORD3: word3_r <= pwdata[15:0];
                default: ;
            endcase
        end
    end

    // Enables, plain software bits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_complete_irq_en_r <= 1'b0;
            single_fault_irq_en_r <= 1'b0;
        end else if (wr_acc) begin
            if (paddr == nvpo_pkg::OFS_CMD_CONFIG)
                cmd_complete_irq_en_r <= pwdata[nvpo_pkg::CCFG_CMD_COMPLETE_IE];
            if (paddr == nvpo_pkg::OFS_ERR_CONFIG)
                single_fault_irq_en_r <= pwdata[nvpo_pkg::ECFG_SINGLE_FAULT_IE];
        end
    end

    // Sequencer: count down the execution time after launch
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= NVPO_IDLE;
            cnt_r <= '0;
        end else begin
            unique case (st_r)
                NVPO_IDLE: if (launch) begin
                    st_r <= NVPO_BUSY;
                    cnt_r <= nvpo_pkg::EXEC_CYCLES - 4'h1;
                end
                NVPO_BUSY: begin
                    if (done) begin
                        st_r <= NVPO_IDLE;
                    end else begin
                        cnt_r <= cnt_r - 4'h1;
                    end
                end
            endcase
        end
    end

    // Command status; error bits are write-one-to-clear, set wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_complete_flag_r <= 1'b1;
            access_error_r <= 1'b0;
            prot_violation_r <= 1'b0;
        end else begin
            if (launch)
                cmd_complete_flag_r <= 1'b0; // RULE_23
            else if (done)
                cmd_complete_flag_r <= 1'b1; // RULE_23
            if (done && cmd_err)
                access_error_r <= 1'b1; // RULE_24
            else if (wr_acc && paddr == nvpo_pkg::OFS_CMD_STATUS &&
                     pwdata[nvpo_pkg::CST_ACCESS_ERROR])
                access_error_r <= 1'b0;
            // Violation is never raised by this command, only cleared
            if (wr_acc && paddr == nvpo_pkg::OFS_CMD_STATUS &&
                pwdata[nvpo_pkg::CST_PROT_VIOLATION])
                prot_violation_r <= 1'b0; // RULE_24
        end
    end

    // Single-bit fault flag; a new fault in the clearing cycle is kept
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sf_prev_r <= 1'b0;
            single_fault_flag_r <= 1'b0;
        end else begin
            sf_prev_r <= sf_sync;
            if (sf_rise)
                single_fault_flag_r <= 1'b1;
            else if (wr_acc && paddr == nvpo_pkg::OFS_ERR_STATUS &&
                     pwdata[nvpo_pkg::EST_SINGLE_FAULT])
                single_fault_flag_r <= 1'b0;
        end
    end

    // Protection registers, save area and override status
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pflash_prot_r <= nvpo_pkg::PFLASH_PROT_RST;
            eeprom_prot_r <= nvpo_pkg::EEPROM_PROT_RST;
            save_pflash_r <= nvpo_pkg::PFLASH_PROT_RST;
            save_eeprom_r <= nvpo_pkg::EEPROM_PROT_RST;
            override_active_r <= 1'b0;
        end else if (done) begin
            if (cmd_err) begin // RULE_11
                // Failed launch touches nothing
            end else if (key_match) begin
                save_pflash_r <= pflash_prot_r; // RULE_05 RULE_12
                save_eeprom_r <= eeprom_prot_r; // RULE_05 RULE_12
                if (sel[0])
                    pflash_prot_r <= word2_r[7:0]; // RULE_06 RULE_07
                if (sel[1])
                    eeprom_prot_r <= word3_r[7:0]; // RULE_06 RULE_07
                override_active_r <= 1'b1; // RULE_08
            end else begin
                // Saved copy wins over any direct write made meanwhile
                pflash_prot_r <= save_pflash_r; // RULE_09 RULE_13 RULE_14
                eeprom_prot_r <= save_eeprom_r; // RULE_09 RULE_13 RULE_14
                override_active_r <= 1'b0; // RULE_09
            end
        end else if (wr_acc && !busy) begin
            if (paddr == nvpo_pkg::OFS_PFLASH_PROT)
                pflash_prot_r <= pwdata[7:0];
            if (paddr == nvpo_pkg::OFS_EEPROM_PROT)
                eeprom_prot_r <= pwdata[7:0];
        end
    end

    // Interrupt requests; no wait-mode gating so completion can wake the core
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_irq_r <= 1'b0;
            err_irq_r <= 1'b0;
        end else begin
            cmd_irq_r <= cmd_complete_flag_r & cmd_complete_irq_en_r; // RULE_20 RULE_22
            err_irq_r <= single_fault_flag_r & single_fault_irq_en_r; // RULE_21
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign cmd_irq = cmd_irq_r;
    assign err_irq = err_irq_r;

    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_launch_cycle;
        launch |=> !cmd_complete_flag_r [*4] ##1 cmd_complete_flag_r;
    endproperty
    a_launch_cycle: assert property (p_launch_cycle) // RULE_23
        else $error("complete flag timing wrong after launch");

    property p_invalid_key;
        done && !cmd_err && word1_r == nvpo_pkg::KEY_ERASED |=> !override_active_r;
    endproperty
    a_invalid_key: assert property (p_invalid_key) // RULE_03
        else $error("all-ones key left override active");

    property p_erased_cfg;
        done && cfg_key == nvpo_pkg::KEY_ERASED |=> !override_active_r;
    endproperty
    a_erased_cfg: assert property (p_erased_cfg) // RULE_10
        else $error("override active with erased stored key");

    property p_match_apply;
        done && !cmd_err && key_match |=> override_active_r &&
            save_pflash_r == $past(pflash_prot_r) &&
            pflash_prot_r == ($past(sel[0]) ? $past(word2_r[7:0]) : $past(pflash_prot_r)) &&
            eeprom_prot_r == ($past(sel[1]) ? $past(word3_r[7:0]) : $past(eeprom_prot_r));
    endproperty
    a_match_apply: assert property (p_match_apply) // RULE_06
        else $error("override did not apply selected values");

    property p_restore;
        done && !cmd_err && !key_match |=> !override_active_r &&
            pflash_prot_r == save_pflash_r && eeprom_prot_r == save_eeprom_r;
    endproperty
    a_restore: assert property (p_restore) // RULE_09
        else $error("restore did not reload saved values");

    property p_err_keep;
        done && cmd_err |=> access_error_r && $stable(pflash_prot_r) &&
            $stable(eeprom_prot_r) && $stable(override_active_r);
    endproperty
    a_err_keep: assert property (p_err_keep) // RULE_11
        else $error("erroneous launch modified protection");

    property p_bad_index;
        done && !(idx_r inside {3'h1, 3'h2, 3'h3}) |=> access_error_r;
    endproperty
    a_bad_index: assert property (p_bad_index) // RULE_15
        else $error("bad index not flagged");

    property p_no_saved;
        done && !key_match && !override_active_r |=> access_error_r;
    endproperty
    a_no_saved: assert property (p_no_saved) // RULE_17
        else $error("restore without saved values not flagged");

    property p_sel_none;
        done && sel == 2'h0 && (idx_r != 3'h1 || key_valid) |=> access_error_r;
    endproperty
    a_sel_none: assert property (p_sel_none) // RULE_18 RULE_19
        else $error("empty selection not flagged");

    property p_cmd_irq;
        cmd_complete_flag_r && cmd_complete_irq_en_r ##1
            cmd_complete_flag_r && cmd_complete_irq_en_r |-> cmd_irq;
    endproperty
    a_cmd_irq: assert property (p_cmd_irq) // RULE_20
        else $error("command interrupt missing");

    property p_err_irq;
        !(single_fault_flag_r && single_fault_irq_en_r) |=> !err_irq;
    endproperty
    a_err_irq: assert property (p_err_irq) // RULE_21
        else $error("error interrupt without cause");

    property p_no_violation;
        !$rose(prot_violation_r);
    endproperty
    a_no_violation: assert property (p_no_violation) // RULE_24
        else $error("violation raised by override command");

    c_override: cover property (done && !cmd_err && key_match);
    c_restore: cover property (done && !cmd_err && !key_match);
    c_error: cover property (done && cmd_err);
    c_fault_irq: cover property (sf_rise ##[1:8] err_irq);

endmodule // nvpo_top

`default_nettype wire

// ---- nvpo_dummy_end.sv ----
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ---- nvpo_top_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none

module nvpo_top_tb_top;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [15:0] cfg_key = 16'h5A3C;
    logic cmd_allowed = 1'b1;
    logic single_fault_evt = 1'b0;
    logic cmd_irq;
    logic err_irq;
    logic [31:0] rd;
    logic err;
    int bad_count = 0;
    int checks_done = 0;
    logic [1:0] e_sel [7] = '{2'h3, 2'h3, 2'h3, 2'h0, 2'h0, 2'h0, 2'h3};
    logic [2:0] e_idx [7] = '{3'h0, 3'h4, 3'h7, 3'h2, 3'h3, 3'h1, 3'h3};

    // Bus clock, 100 ns period
    always #50 pclk = ~pclk;

    nvpo_top u_nvpo_top (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .cfg_key(cfg_key), .cmd_allowed(cmd_allowed), .single_fault_evt(single_fault_evt),
        .cmd_irq(cmd_irq), .err_irq(err_irq)
    );

    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk_word(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic chk_bit(input string name, input logic exp, input logic got);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %s expected %b seen %b", name, exp, got);
        end
    endtask

    // One APB transfer; request held until pready is seen high at an edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 16; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        chk_bit("pready", 1'b1, pready);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic chk_reg(input logic [7:0] a, input logic [31:0] exp, input string name);
        apb(1'b0, a, 32'h0);
        chk_word(name, exp, rd);
        // A mapped register must never answer with a bus error
        chk_bit("pslverr mapped", 1'b0, err);
    endtask

    task automatic chk_prot(input logic [7:0] fp, input logic [7:0] ep, input logic ov);
        chk_reg(nvpo_pkg::OFS_PFLASH_PROT, {24'h0, fp}, "pflash_prot_reg");
        chk_reg(nvpo_pkg::OFS_EEPROM_PROT, {24'h0, ep}, "eeprom_prot_reg");
        chk_reg(nvpo_pkg::OFS_PROT_STATUS, {24'h0, ov, 7'h00}, "override_active");
    endtask

    // Loads the parameters, launches, and polls until the flag sets again
    task automatic run_cmd(input logic [1:0] sel, input logic [15:0] key, input logic [7:0] fp,
                           input logic [7:0] ep, input logic [2:0] idx, input logic exp_err);
        int n;
        apb(1'b1, nvpo_pkg::OFS_PARAM_WORD0, {16'h0, nvpo_pkg::CMD_PROT_OVERRIDE, 6'h00, sel});
        apb(1'b1, nvpo_pkg::OFS_PARAM_WORD1, {16'h0, key});
        apb(1'b1, nvpo_pkg::OFS_PARAM_WORD2, {24'h0, fp});
        apb(1'b1, nvpo_pkg::OFS_PARAM_WORD3, {24'h0, ep});
        apb(1'b1, nvpo_pkg::OFS_PARAM_INDEX, {29'h0, idx});
        apb(1'b1, nvpo_pkg::OFS_CMD_STATUS, 32'h30);
        apb(1'b1, nvpo_pkg::OFS_CMD_STATUS, 32'h80);
        repeat (2) @(posedge pclk);
        chk_bit("cmd_irq busy", 1'b0, cmd_irq);
        apb(1'b0, nvpo_pkg::OFS_CMD_STATUS, 32'h0);
        chk_bit("busy flag", 1'b0, rd[7]);
        n = 0;
        while (rd[7] !== 1'b1 && n < 20) begin
            apb(1'b0, nvpo_pkg::OFS_CMD_STATUS, 32'h0);
            n++;
        end
        chk_bit("cmd_complete_flag", 1'b1, rd[7]);
        chk_bit("prot_violation", 1'b0, rd[4]);
        chk_bit("access_error", exp_err, rd[5]);
        repeat (2) @(posedge pclk);
        chk_bit("cmd_irq done", 1'b1, cmd_irq);
    endtask

    // Hang guard, well beyond the expected run length
    initial begin
        #(100 * 20000);
        bad_count++;
        $display("ERROR watchdog expected finish seen timeout");
        conclude();
    end

    // Main sequence
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        chk_prot(nvpo_pkg::PFLASH_PROT_RST, nvpo_pkg::EEPROM_PROT_RST, 1'b0);
        chk_reg(nvpo_pkg::OFS_CMD_STATUS, 32'h80, "cmd_status_reg");
        apb(1'b1, 8'h30, 32'h1);
        chk_bit("pslverr write", 1'b1, err);
        apb(1'b0, 8'h30, 32'h0);
        chk_bit("pslverr read", 1'b1, err);
        $display("test reset_map done");
        apb(1'b1, nvpo_pkg::OFS_PFLASH_PROT, 32'h21);
        apb(1'b1, nvpo_pkg::OFS_EEPROM_PROT, 32'h43);
        apb(1'b1, nvpo_pkg::OFS_CMD_CONFIG, 32'h80);
        repeat (2) @(posedge pclk);
        chk_bit("cmd_irq idle", 1'b1, cmd_irq);
        run_cmd(2'h3, 16'h1111, 8'hA5, 8'h3C, nvpo_pkg::IDX_EEPROM, 1'b1);
        chk_prot(8'h21, 8'h43, 1'b0);
        run_cmd(2'h3, 16'h5A3C, 8'hA5, 8'h3C, nvpo_pkg::IDX_EEPROM, 1'b0);
        chk_prot(8'hA5, 8'h3C, 1'b1);
        $display("test override done");
        // Direct write while active, then a second override refreshes the save area
        apb(1'b1, nvpo_pkg::OFS_PFLASH_PROT, 32'h77);
        run_cmd(2'h1, 16'h5A3C, 8'h0F, 8'hEE, nvpo_pkg::IDX_PFLASH, 1'b0);
        chk_prot(8'h0F, 8'h3C, 1'b1);
        apb(1'b1, nvpo_pkg::OFS_EEPROM_PROT, 32'h99);
        run_cmd(2'h3, 16'h2222, 8'h00, 8'h00, nvpo_pkg::IDX_EEPROM, 1'b0);
        chk_prot(8'h77, 8'h3C, 1'b0);
        run_cmd(2'h2, 16'h5A3C, 8'h00, 8'h55, nvpo_pkg::IDX_EEPROM, 1'b0);
        chk_prot(8'h77, 8'h55, 1'b1);
        run_cmd(2'h0, 16'hFFFF, 8'h00, 8'h00, nvpo_pkg::IDX_KEY_ONLY, 1'b0);
        chk_prot(8'h77, 8'h3C, 1'b0);
        $display("test restore done");
        run_cmd(2'h3, 16'h5A3C, 8'hC3, 8'h5A, nvpo_pkg::IDX_EEPROM, 1'b0);
        // Faulty launches must leave the overridden values alone
        for (int i = 0; i < 7; i++) begin
            cmd_allowed <= (i != 6);
            run_cmd(e_sel[i], 16'h5A3C, 8'h11, 8'h22, e_idx[i], 1'b1);
            chk_prot(8'hC3, 8'h5A, 1'b1);
        end
        cmd_allowed <= 1'b1;
        $display("test errors done");
        cfg_key <= 16'hFFFF;
        run_cmd(2'h3, 16'hFFFF, 8'h11, 8'h22, nvpo_pkg::IDX_EEPROM, 1'b0);
        chk_prot(8'h77, 8'h3C, 1'b0);
        run_cmd(2'h3, 16'hFFFF, 8'h11, 8'h22, nvpo_pkg::IDX_EEPROM, 1'b1);
        chk_prot(8'h77, 8'h3C, 1'b0);
        $display("test erased_key done");
        // Fault flag is set by the rising edge only, so clearing while held must stick
        apb(1'b1, nvpo_pkg::OFS_ERR_CONFIG, 32'h1);
        single_fault_evt <= 1'b1;
        repeat (6) @(posedge pclk);
        chk_reg(nvpo_pkg::OFS_ERR_STATUS, 32'h1, "single_fault_flag");
        chk_bit("err_irq set", 1'b1, err_irq);
        apb(1'b1, nvpo_pkg::OFS_ERR_CONFIG, 32'h0);
        repeat (2) @(posedge pclk);
        chk_bit("err_irq masked", 1'b0, err_irq);
        apb(1'b1, nvpo_pkg::OFS_ERR_CONFIG, 32'h1);
        apb(1'b1, nvpo_pkg::OFS_ERR_STATUS, 32'h1);
        repeat (2) @(posedge pclk);
        chk_bit("err_irq cleared", 1'b0, err_irq);
        single_fault_evt <= 1'b0;
        apb(1'b1, nvpo_pkg::OFS_CMD_CONFIG, 32'h0);
        repeat (2) @(posedge pclk);
        chk_bit("cmd_irq masked", 1'b0, cmd_irq);
        $display("test interrupts done");
        conclude();
    end
endmodule // nvpo_top_tb_top

`default_nettype wire
